// ---- mcb_bond.sv ----
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mcb_map.svh"

// Function
// - Bond status codes: rsvd, add, delete, normal.
// - Master sends its master channel buffer status.
// - Bond status updates at character rate.
// - Drive bus only as quad master on reference_clock.
// - Select pins choose the master receive channel.
// - Role strap low master, high slave.
// - Role strap ignored unless quad reference_clock mode.
// - All-bonded line is wired-AND open drain.
// - Line low until resolved and framing valid.
// - Drive line only in quad reference_clock mode.
// - Inhibit low blocks alignment until all seen.
// - Inhibit high lets each seen group channel align.
// - No bonding unless master channel in group.
module mcb_bond (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  master_sel_n,
  input  wire logic                  align_inhibit_n,
  input  wire logic                  rx_select_hi_b,
  input  wire logic                  rx_select_hi_d,
  input  wire logic [1:0]            bond_status_bus_i,
  output logic [1:0]                 bond_status_bus_o,
  output logic [1:0]                 bond_status_bus_oe,
  input  wire logic                  bond_all_i,
  output logic                       bond_all_o,
  output logic                       bond_all_oe,
  input  wire logic                  char_en,
  input  wire mcb_pkg::mcb_chan_t    seq_seen,
  input  wire mcb_pkg::mcb_chan_t    framing_valid,
  input  wire logic [7:0]            eb_status,
  output mcb_pkg::mcb_chan_t         align_allow,
  output mcb_pkg::mcb_bs_e           eb_cmd,
  output logic                       eb_cmd_valid
);
  import mcb_pkg::*;

  logic [`MCB_SYNC_W-1:0] pin_s;
  logic                   master_n_s;
  logic                   inhibit_n_s;
  logic [1:0]             sel_s;
  logic [1:0]             bus_in_s;
  logic                   line_s;
  logic                   quad_reg;
  logic                   refrx_reg;
  mcb_chan_t              group_reg;
  logic                   active;
  logic                   is_master;
  logic                   master_member;
  logic                   all_seen;
  logic                   bond_ready;
  logic [1:0]             master_raw;
  mcb_bs_e                master_cmd;
  mcb_bs_e                slave_cmd;
  mcb_bs_e                bs_reg;
  logic                   drive_en_reg;
  logic                   bond_all_oe_reg;
  mcb_state_e             state_reg;
  mcb_state_e             state_next;
  logic                   aw_hold_reg;
  logic                   w_hold_reg;
  logic [3:0]             awaddr_reg;
  logic [31:0]            wdata_reg;
  logic                   wstrb0_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;
  logic [31:0]            stat_word;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  mcb_sync #(.WIDTH (`MCB_SYNC_W)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({master_sel_n, align_inhibit_n, rx_select_hi_d,
            rx_select_hi_b, bond_status_bus_i, bond_all_i}),
    .q    (pin_s)
  );

  assign master_n_s  = pin_s[6];
  assign inhibit_n_s = pin_s[5];
  assign sel_s       = pin_s[4:3];
  assign bus_in_s    = pin_s[2:1];
  assign line_s      = pin_s[0];

  // ****************************************************************
  // Mode and role decode.
  // ****************************************************************
  assign active        = quad_reg & refrx_reg;
  assign is_master     = active & ~master_n_s;
  assign master_member = group_reg[sel_s];
  assign all_seen      = (&(seq_seen | ~group_reg)) & (|group_reg);
  assign bond_ready    = (state_reg == MCB_ST_BONDED) &
                         (&(framing_valid | ~group_reg));
  assign master_raw    = eb_status[{sel_s, 1'b0} +: 2];
  assign master_cmd    = (master_raw == `MCB_BS_RSVD) ? MCB_CMD_NORM :
                         mcb_bs_e'(master_raw);
  assign slave_cmd     = (bus_in_s == `MCB_BS_RSVD) ? MCB_CMD_NORM :
                         mcb_bs_e'(bus_in_s);

  // ****************************************************************
  // Bonding resolution state machine.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MCB_ST_OFF: begin
        if (active) begin
          state_next = MCB_ST_RESOLVE;
        end
      end
      MCB_ST_RESOLVE: begin
        if (!active) begin
          state_next = MCB_ST_OFF;
        end else if (master_member && all_seen) begin
          state_next = MCB_ST_BONDED;
        end
      end
      MCB_ST_BONDED: begin
        if (!active) begin
          state_next = MCB_ST_OFF;
        end else if (!master_member || !all_seen) begin
          state_next = MCB_ST_RESOLVE;
        end
      end
      default: begin
        state_next = MCB_ST_OFF;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= MCB_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Alignment permission per channel.
  // ****************************************************************
  for (genvar i = 0; i < 4; i++) begin : g_align
    always_comb begin
      align_allow[i] = active & master_member & group_reg[i] &
                       seq_seen[i] & (inhibit_n_s | all_seen);
    end
  end

  // ****************************************************************
  // Bond status bus and local command.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bs_reg <= MCB_CMD_NORM;
    end else if (char_en) begin
      bs_reg <= is_master ? master_cmd : MCB_CMD_NORM;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      drive_en_reg <= 1'b0;
    end else begin
      drive_en_reg <= is_master & (&group_reg);
    end
  end

  assign bond_status_bus_o  = 2'h0;
  assign bond_status_bus_oe = {2{drive_en_reg}} & ~bs_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      eb_cmd       <= MCB_CMD_NORM;
      eb_cmd_valid <= 1'b0;
    end else begin
      eb_cmd_valid <= char_en & active;
      if (char_en && active) begin
        eb_cmd <= is_master ? master_cmd : slave_cmd;
      end
    end
  end

  // ****************************************************************
  // All-bonded open-drain line.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bond_all_oe_reg <= 1'b0;
    end else begin
      bond_all_oe_reg <= active & ~bond_ready;
    end
  end

  assign bond_all_o  = 1'b0;
  assign bond_all_oe = bond_all_oe_reg;

  // ****************************************************************
  // Register bus write channel.
  // ****************************************************************
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (aw_hold_reg && w_hold_reg) begin
      aw_hold_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (aw_hold_reg && w_hold_reg) begin
      w_hold_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `MCB_RESP_OKAY;
    end else if (aw_hold_reg && w_hold_reg) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (awaddr_reg == `MCB_CTRL_ADDR ||
                     awaddr_reg == `MCB_STAT_ADDR) ?
                    `MCB_RESP_OKAY : `MCB_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      quad_reg  <= `MCB_QUAD_RST;
      refrx_reg <= `MCB_REFRX_RST;
      group_reg <= `MCB_GROUP_RST;
    end else if (aw_hold_reg && w_hold_reg && wstrb0_reg &&
                 awaddr_reg == `MCB_CTRL_ADDR) begin
      quad_reg  <= wdata_reg[`MCB_CTRL_QUAD];
      refrx_reg <= wdata_reg[`MCB_CTRL_REFRX];
      group_reg <= wdata_reg[`MCB_CTRL_GRP_HI:`MCB_CTRL_GRP_LO];
    end
  end

  // ****************************************************************
  // Register bus read channel.
  // ****************************************************************
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`MCB_ST_SEEN_HI:`MCB_ST_SEEN_LO] = seq_seen;
    stat_word[`MCB_ST_FRM_HI:`MCB_ST_FRM_LO]   = framing_valid;
    stat_word[`MCB_ST_ACTIVE]                  = active;
    stat_word[`MCB_ST_MASTER]                  = is_master;
    stat_word[`MCB_ST_BONDED]                  = state_reg == MCB_ST_BONDED;
    stat_word[`MCB_ST_LINE]                    = line_s;
    stat_word[`MCB_ST_CMD_HI:`MCB_ST_CMD_LO]   = eb_cmd;
  end

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `MCB_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `MCB_RESP_OKAY;
      if (s_axi_araddr == `MCB_CTRL_ADDR) begin
        rdata_reg <= {24'h00_0000, group_reg, 2'h0, refrx_reg, quad_reg};
      end else if (s_axi_araddr == `MCB_STAT_ADDR) begin
        rdata_reg <= stat_word;
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= `MCB_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_bus_no_rsvd: assert property (
    drive_en_reg |-> bond_status_bus_oe != 2'h3)
    else $error("Reserved code driven on bond status bus.");
  a_master_source: assert property (
    char_en && is_master |=> bs_reg == ($past(master_raw) == 2'h0 ?
      MCB_CMD_NORM : $past(master_raw)))
    else $error("Bond status does not follow master channel.");
  a_char_rate: assert property (
    !char_en |=> $stable(bs_reg))
    else $error("Bond status changed off the character rate.");
  a_drive_gate: assert property (
    bond_status_bus_oe != 2'h0 |-> $past(is_master && group_reg == 4'hF))
    else $error("Bond status bus driven while not quad master.");
  a_inactive_quiet: assert property (
    !active ##1 !active |-> bond_status_bus_oe == 2'h0 && !bond_all_oe)
    else $error("Pins driven outside quad reference_clock mode.");
  a_line_hold: assert property (
    active && state_reg != MCB_ST_BONDED |=> bond_all_oe && !bond_all_o)
    else $error("All-bonded line released before resolution.");
  a_line_release: assert property (
    active && bond_ready ##1 active && bond_ready |-> !bond_all_oe)
    else $error("All-bonded line held after bonding.");
  a_inhibit_block: assert property (
    active && !inhibit_n_s && !all_seen |-> align_allow == 4'h0)
    else $error("Alignment allowed before all channels saw sequence.");
  a_free_align: assert property (
    active && inhibit_n_s && master_member |->
      align_allow == (seq_seen & group_reg))
    else $error("Seen channel not allowed to align.");
  a_master_member: assert property (
    !master_member |-> align_allow == 4'h0 ##1
      state_reg != MCB_ST_BONDED)
    else $error("Bonding without master channel in group.");
  a_slave_apply: assert property (
    char_en && active && !is_master |=> eb_cmd_valid &&
      eb_cmd == ($past(bus_in_s) == 2'h0 ? MCB_CMD_NORM : $past(bus_in_s)))
    else $error("Slave did not apply received command.");
  c_master_bonded: cover property (
    is_master && drive_en_reg && state_reg == MCB_ST_BONDED);
  c_slave_add: cover property (
    !is_master && eb_cmd_valid && eb_cmd == MCB_CMD_ADD);
  c_line_release: cover property (bond_all_oe ##1 active && !bond_all_oe);
  c_free_align: cover property (
    inhibit_n_s && !all_seen && align_allow != 4'h0);

endmodule // mcb_bond

// ---- mcb_map.svh ----
`ifndef MCB_MAP_SVH
`define MCB_MAP_SVH

// ****************************************************************
// Register offsets and reset values.
// ****************************************************************
`define MCB_ADDR_W       4
`define MCB_CTRL_ADDR    4'h0
`define MCB_STAT_ADDR    4'h4
`define MCB_GROUP_RST    4'hF
`define MCB_QUAD_RST     1'h0
`define MCB_REFRX_RST    1'h0

// ****************************************************************
// Control field positions.
// ****************************************************************
`define MCB_CTRL_QUAD    0
`define MCB_CTRL_REFRX   1
`define MCB_CTRL_GRP_LO  4
`define MCB_CTRL_GRP_HI  7

// ****************************************************************
// Status field positions.
// ****************************************************************
`define MCB_ST_SEEN_LO   0
`define MCB_ST_SEEN_HI   3
`define MCB_ST_FRM_LO    4
`define MCB_ST_FRM_HI    7
`define MCB_ST_ACTIVE    8
`define MCB_ST_MASTER    9
`define MCB_ST_BONDED    10
`define MCB_ST_LINE      11
`define MCB_ST_CMD_LO    12
`define MCB_ST_CMD_HI    13

// ****************************************************************
// Bond status codes and bus answers.
// ****************************************************************
`define MCB_BS_RSVD      2'h0
`define MCB_BS_ADD       2'h1
`define MCB_BS_DEL       2'h2
`define MCB_BS_NORM      2'h3
`define MCB_RESP_OKAY    2'h0
`define MCB_RESP_DECERR  2'h3
`define MCB_SYNC_W       7

`endif

// ---- mcb_peer.sv ----
`timescale 1ns/1ps

// **********
// Far-side device sharing the bond status and all-bonded lines.
// **********
module mcb_peer (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       drive,
  input  wire logic [1:0] code,
  input  wire logic       hold_all,
  input  wire logic [1:0] bus_lvl,
  output logic      [1:0] bus_oe,
  output logic            all_oe,
  output logic      [1:0] seen
);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_oe <= 2'h0;
      all_oe <= 1'b0;
      seen   <= 2'h3;
    end else begin
      bus_oe <= drive ? ~code : 2'h0;
      all_oe <= hold_all;
      seen   <= bus_lvl;
    end
  end
endmodule // mcb_peer

// ---- mcb_pkg.sv ----
`include "mcb_map.svh"

package mcb_pkg;

  typedef enum logic [1:0] {
    MCB_CMD_RSVD = `MCB_BS_RSVD,
    MCB_CMD_ADD  = `MCB_BS_ADD,
    MCB_CMD_DEL  = `MCB_BS_DEL,
    MCB_CMD_NORM = `MCB_BS_NORM
  } mcb_bs_e;

  typedef enum logic [2:0] {
    MCB_ST_OFF     = 3'h1,
    MCB_ST_RESOLVE = 3'h2,
    MCB_ST_BONDED  = 3'h4
  } mcb_state_e;

  typedef logic [3:0] mcb_chan_t;

endpackage

// ---- mcb_sync.sv ----
`timescale 1ns/1ps

module mcb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // ****************************************************************
  // Two flip-flop synchroniser.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // mcb_sync

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "mcb_map.svh"

module tb_top;
  import mcb_pkg::*;
  logic        clk, rstn, master_sel_n, align_inhibit_n, rx_select_hi_b;
  logic        rx_select_hi_d, char_en, bond_all_i, bond_all_o, bond_all_oe;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, eb_cmd_valid, hold_all, p_all_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bond_status_bus_i, bond_status_bus_o;
  logic [1:0]  bond_status_bus_oe, p_code, p_oe, p_seen, exp_cmd, r;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [7:0]  eb_status;
  mcb_chan_t   seq_seen, framing_valid, align_allow;
  mcb_bs_e     eb_cmd;
  int          fails, comparisons;

  // **********
  // Open-drain lines with pull-ups, and the far-side device.
  // **********
  assign bond_status_bus_i = ~(bond_status_bus_oe | p_oe);
  assign bond_all_i = ~(bond_all_oe | p_all_oe);

  mcb_bond dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_sel_n, .align_inhibit_n, .rx_select_hi_b, .rx_select_hi_d,
    .bond_status_bus_i, .bond_status_bus_o, .bond_status_bus_oe, .bond_all_i,
    .bond_all_o, .bond_all_oe, .char_en, .seq_seen, .framing_valid,
    .eb_status, .align_allow, .eb_cmd, .eb_cmd_valid);

  mcb_peer peer (.clk, .rstn, .drive(master_sel_n), .code(p_code),
    .hold_all, .bus_lvl(bond_status_bus_i), .bus_oe(p_oe), .all_oe(p_all_oe),
    .seen(p_seen));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // **********
  // Bus cycles, comparisons and the verdict.
  // **********
  task automatic conclude();
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic [3:0] e,
                         input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] rs);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d  = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [1:0] fix(input logic [1:0] c);
    return (c == `MCB_BS_RSVD) ? `MCB_BS_NORM : c;
  endfunction

  // **********
  // One character with random pins under a given control word.
  // **********
  task automatic step(input logic [7:0] ctrl);
    logic       act, mst, inm, alls, bnd, drv, ao;
    logic [1:0] code;
    logic [3:0] allow;
    int         m;
    axi_wr(`MCB_CTRL_ADDR, {24'h0, ctrl}, 4'hF, r);
    chk_pin("ctrl_bresp", `MCB_RESP_OKAY, r);
    @(posedge clk);
    seq_seen        <= 4'($urandom | $urandom);
    framing_valid   <= 4'($urandom | $urandom);
    eb_status       <= 8'($urandom);
    p_code          <= 2'($urandom);
    rx_select_hi_b  <= 1'($urandom);
    rx_select_hi_d  <= 1'($urandom);
    master_sel_n    <= 1'($urandom);
    align_inhibit_n <= 1'($urandom);
    hold_all        <= ($urandom % 4 == 0);
    repeat (6) @(posedge clk);
    char_en <= 1'b1;
    @(posedge clk);
    char_en <= 1'b0;
    #1;
    m    = {rx_select_hi_d, rx_select_hi_b};
    act  = ctrl[0] & ctrl[1];
    mst  = act & ~master_sel_n;
    inm  = ctrl[4 + m];
    alls = &(seq_seen | ~ctrl[7:4]);
    bnd  = act & inm & alls;
    code = fix(eb_status[2 * m +: 2]);
    drv  = mst & (ctrl[7:4] == 4'hF);
    ao   = act & ~(bnd & &(framing_valid | ~ctrl[7:4]));
    for (int i = 0; i < 4; i++) begin
      allow[i] = act & inm & ctrl[4 + i] & seq_seen[i]
                 & (align_inhibit_n | alls);
    end
    if (act) exp_cmd = mst ? code : fix(p_code);
    chk_pin("align_allow", allow, align_allow);
    chk_pin("bus_oe", drv ? {2'h0, ~code} : 4'h0, bond_status_bus_oe);
    chk_pin("all_oe", {3'h0, ao}, bond_all_oe);
    chk_pin("cmd_valid", {3'h0, act}, eb_cmd_valid);
    chk_pin("eb_cmd", {2'h0, exp_cmd}, eb_cmd);
    chk_pin("od_level", 4'h0, {1'b0, bond_all_o, bond_status_bus_o});
    axi_rd(`MCB_STAT_ADDR, got, r);
    chk_pin("stat_rresp", `MCB_RESP_OKAY, r);
    chk_word("status", {18'h0, exp_cmd, ~(ao | hold_all), bnd, mst, act,
             framing_valid, seq_seen}, got);
    if (drv) chk_pin("wire_code", {2'h0, code}, {2'h0, p_seen});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    {rstn, master_sel_n, align_inhibit_n, rx_select_hi_b} = 4'h0;
    {rx_select_hi_d, char_en, hold_all, p_code, eb_status} = 13'h0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = 41'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = 6'h0;
    {s_axi_arvalid, s_axi_rready, seq_seen, framing_valid} = 10'h0;
    fails       = 0;
    comparisons = 0;
    exp_cmd     = `MCB_BS_NORM;
    void'($urandom(32'hF408));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk_pin("rst_allow", 4'h0, align_allow);
    chk_pin("rst_oe", 4'h0, {1'b0, bond_all_oe, bond_status_bus_oe});
    chk_pin("rst_cmd", {2'h0, `MCB_BS_NORM}, eb_cmd);
    axi_rd(`MCB_CTRL_ADDR, got, r);
    chk_word("ctrl_rst", {24'h0, `MCB_GROUP_RST, 2'h0, `MCB_REFRX_RST,
             `MCB_QUAD_RST}, got);
    chk_pin("ctrl_rresp", `MCB_RESP_OKAY, r);
    axi_wr(4'h8, 32'h0000_00F3, 4'hF, r);
    chk_pin("bad_bresp", `MCB_RESP_DECERR, r);
    axi_rd(4'hC, got, r);
    chk_word("bad_read", {30'h0, `MCB_RESP_DECERR}, {got[29:0], r});
    axi_wr(`MCB_CTRL_ADDR, 32'h0000_0003, 4'hE, r);
    axi_rd(`MCB_CTRL_ADDR, got, r);
    chk_word("ctrl_strb", 32'h0000_00F0, got);
    step(8'hF3);
    step(8'hF0);
    step(8'h73);
    repeat (60) begin
      step({($urandom % 3 == 0) ? 4'($urandom) : 4'hF, 2'h0,
            1'($urandom % 4 != 0), 1'($urandom % 4 != 0)});
    end
    conclude();
  end
endmodule // tb_top
